// >>> inc/fab_pkg.sv
// Package for the flash address bank mode block
// Functional notes
// - Eight-bit volatile bank register supplies A30..A24
// - Bank bit 7 selects four-byte addressing
// - Four-byte mode: command supplies all address bits
// - Three-byte mode: bank bits select 128-Mbit segment
// - Command 16h returns current bank value
// - Command 17h loads exactly one data byte
// - Dedicated four-byte commands carry full address
// - Software reset or power cycle exits four-byte mode
package fab_pkg;
    localparam logic [7:0] FAB_CMD_BANK_READ = 8'h16;
    localparam logic [7:0] FAB_CMD_BANK_WRITE = 8'h17;
    localparam logic [7:0] FAB_BANK_RESET = 8'h00;
    localparam int FAB_MODE_BIT = 7;
    localparam int FAB_SEG_MSB = 6;
    localparam int FAB_BYTE_BITS = 8;
    localparam logic [2:0] FAB_BIT_LAST = 3'h7;
    localparam logic [2:0] FAB_BIT_ZERO = 3'h0;
    localparam logic [2:0] FAB_BIT_STEP = 3'h1;
    localparam int FAB_SYNC_STAGES = 3;
    localparam int FAB_ADDR_LOW_BITS = 24;
    localparam logic [2:0] FAB_SYNC_HIGH = 3'h7;
    localparam logic [2:0] FAB_SYNC_LOW = 3'h0;
    localparam logic FAB_SEL_IDLE = 1'h1;
    localparam logic FAB_PIN_IDLE = 1'h0;
    localparam logic [7:0] FAB_BYTE_ZERO = 8'h00;
    localparam logic [31:0] FAB_ADDR_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        FAB_ST_CMD = 3'b000,
        FAB_ST_RD = 3'b001,
        FAB_ST_WR = 3'b010,
        FAB_ST_DONE = 3'b011
    } fab_state_t;

    // Address request from the memory command decoder
    typedef struct packed {
        logic [31:0] addr;
        logic wide;
    } fab_addr_req_t;
endpackage

// >>> hw/fab_bank.sv
// Bank register, its serial commands and effective address generation
`timescale 1ns/1ps
module fab_bank (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic soft_reset_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire fab_pkg::fab_addr_req_t req_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic [31:0] eff_addr_out,
    output logic four_byte_out,
    output logic [7:0] bank_out
);
    // Pin synchronisers: three stages, a change counts once stages two and three agree
    localparam int SYNC_TOP = fab_pkg::FAB_SYNC_STAGES - 1;
    localparam int SYNC_MID = fab_pkg::FAB_SYNC_STAGES - 2;
    localparam int BYTE_TOP = fab_pkg::FAB_BYTE_BITS - 1;
    localparam int BYTE_LOW_TOP = fab_pkg::FAB_BYTE_BITS - 2;
    localparam int LOW_TOP = fab_pkg::FAB_ADDR_LOW_BITS - 1;

    // Pin enters stage one; only stage two reads stage one
    function automatic logic [2:0] sync_shift(input logic [2:0] stages, input logic pin);
        return {stages[SYNC_MID:0], pin};
    endfunction

    // One odd sample keeps the old level, so a glitch never makes an edge
    function automatic logic sync_vote(input logic [2:0] stages, input logic held);
        logic level;
        level = held;
        if (stages[SYNC_MID] == stages[SYNC_TOP]) begin
            level = stages[SYNC_TOP];
        end
        return level;
    endfunction

    // Serial bit enters at the bottom; bytes travel MSB first
    function automatic logic [7:0] shift_in(input logic [7:0] bits, input logic bit_in);
        return {bits[BYTE_LOW_TOP:0], bit_in};
    endfunction

    // Bit counter wraps after the eighth bit
    function automatic logic [2:0] bit_step(input logic [2:0] cnt);
        return cnt + fab_pkg::FAB_BIT_STEP;
    endfunction

    // Last bit of a byte
    function automatic logic byte_done(input logic [2:0] cnt);
        return cnt == fab_pkg::FAB_BIT_LAST;
    endfunction

    // Opcode decode: only the two bank commands lead anywhere
    function automatic fab_pkg::fab_state_t decode_op(input logic [7:0] op);
        fab_pkg::fab_state_t st;
        case (op)
            fab_pkg::FAB_CMD_BANK_READ: begin
                st = fab_pkg::FAB_ST_RD;
            end
            fab_pkg::FAB_CMD_BANK_WRITE: begin
                st = fab_pkg::FAB_ST_WR;
            end
            default: begin
                // Foreign opcodes sit out the frame until deselect
                st = fab_pkg::FAB_ST_DONE;
            end
        endcase
        return st;
    endfunction

    // Bank bit 7 or a dedicated wide command passes the whole address
    function automatic logic [31:0] map_addr(input logic [7:0] bank, input fab_pkg::fab_addr_req_t req);
        logic [31:0] addr;
        if (req.wide || bank[fab_pkg::FAB_MODE_BIT]) begin
            addr = req.addr;
        end else begin
            addr = {1'b0, bank[fab_pkg::FAB_SEG_MSB:0], req.addr[LOW_TOP:0]};
        end
        return addr;
    endfunction

    logic [2:0] cs_s_reg, cs_s_next;
    logic [2:0] ck_s_reg, ck_s_next;
    logic [2:0] di_s_reg, di_s_next;
    logic cs_q_reg, cs_q_next;
    logic ck_q_reg, ck_q_next;
    logic di_q_reg, di_q_next;
    logic rise;
    logic fall;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s_reg <= fab_pkg::FAB_SYNC_HIGH;
            ck_s_reg <= fab_pkg::FAB_SYNC_LOW;
            di_s_reg <= fab_pkg::FAB_SYNC_LOW;
            cs_q_reg <= fab_pkg::FAB_SEL_IDLE;
            ck_q_reg <= fab_pkg::FAB_PIN_IDLE;
            di_q_reg <= fab_pkg::FAB_PIN_IDLE;
        end else begin
            cs_s_reg <= cs_s_next;
            ck_s_reg <= ck_s_next;
            di_s_reg <= di_s_next;
            cs_q_reg <= cs_q_next;
            ck_q_reg <= ck_q_next;
            di_q_reg <= di_q_next;
        end
    end

    always_comb begin
        cs_s_next = sync_shift(cs_s_reg, cs_n_in);
        ck_s_next = sync_shift(ck_s_reg, sclk_in);
        di_s_next = sync_shift(di_s_reg, mosi_in);
        cs_q_next = sync_vote(cs_s_reg, cs_q_reg);
        ck_q_next = sync_vote(ck_s_reg, ck_q_reg);
        di_q_next = sync_vote(di_s_reg, di_q_reg);
        // Edges come from the voted level, and only while selected
        rise = ck_q_next & ~ck_q_reg & ~cs_q_next;
        fall = ~ck_q_next & ck_q_reg & ~cs_q_next;
    end

    // Command state
    fab_pkg::fab_state_t st_reg, st_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] bank_reg, bank_next;
    logic miso_reg, miso_next;
    logic oe_reg, oe_next;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= fab_pkg::FAB_ST_CMD;
            cnt_reg <= fab_pkg::FAB_BIT_ZERO;
            sh_reg <= fab_pkg::FAB_BYTE_ZERO;
            bank_reg <= fab_pkg::FAB_BANK_RESET;
            miso_reg <= fab_pkg::FAB_PIN_IDLE;
            oe_reg <= fab_pkg::FAB_PIN_IDLE;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            bank_reg <= bank_next;
            miso_reg <= miso_next;
            oe_reg <= oe_next;
        end
    end

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        bank_next = bank_reg;
        miso_next = miso_reg;
        oe_next = oe_reg;
        if (cs_q_next) begin
            // Deselect aborts any partial command; a short write never lands
            st_next = fab_pkg::FAB_ST_CMD;
            cnt_next = fab_pkg::FAB_BIT_ZERO;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                fab_pkg::FAB_ST_CMD: begin
                    if (rise) begin
                        sh_next = shift_in(sh_reg, di_q_reg);
                        cnt_next = bit_step(cnt_reg);
                        if (byte_done(cnt_reg)) begin
                            cnt_next = fab_pkg::FAB_BIT_ZERO;
                            st_next = decode_op(shift_in(sh_reg, di_q_reg));
                            if (st_next == fab_pkg::FAB_ST_RD) begin
                                // Preload so the first falling edge shows bit 7
                                sh_next = bank_reg;
                            end
                        end
                    end
                end
                fab_pkg::FAB_ST_RD: begin
                    // Shift out on falling edge, MSB first; repeats while selected
                    if (fall) begin
                        oe_next = 1'b1;
                        miso_next = sh_reg[BYTE_TOP];
                        sh_next = shift_in(sh_reg, sh_reg[BYTE_TOP]);
                    end
                end
                fab_pkg::FAB_ST_WR: begin
                    if (rise) begin
                        sh_next = shift_in(sh_reg, di_q_reg);
                        cnt_next = bit_step(cnt_reg);
                        if (byte_done(cnt_reg)) begin
                            bank_next = shift_in(sh_reg, di_q_reg);
                            st_next = fab_pkg::FAB_ST_DONE;
                        end
                    end
                end
                fab_pkg::FAB_ST_DONE: begin
                    // Extra bits after the byte are ignored
                end
                default: st_next = fab_pkg::FAB_ST_CMD;
            endcase
        end
        // Soft reset wins over a write landing in the same cycle
        if (soft_reset_in) begin
            bank_next = fab_pkg::FAB_BANK_RESET;
        end
    end

    // Effective address for the memory core, one cycle after the request
    logic [31:0] addr_reg, addr_next;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg <= fab_pkg::FAB_ADDR_ZERO;
        end else begin
            addr_reg <= addr_next;
        end
    end

    always_comb begin
        addr_next = map_addr(bank_reg, req_in);
    end

    // Outputs come straight from registers
    assign miso_out = miso_reg;
    assign miso_oe_out = oe_reg;
    assign eff_addr_out = addr_reg;
    assign four_byte_out = bank_reg[fab_pkg::FAB_MODE_BIT];
    assign bank_out = bank_reg;
endmodule

// >>> testbench/fab_checker.sv
// Assertion checker for the bank register block
`timescale 1ns/1ps
module fab_checker (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic soft_reset_in,
    input wire logic cs_n_in,
    input wire fab_pkg::fab_addr_req_t req_in,
    input wire logic miso_oe_out,
    input wire logic [31:0] eff_addr_out,
    input wire logic four_byte_out,
    input wire logic [7:0] bank_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_mode_bit_follows: assert property (four_byte_out == bank_out[7])
        else $error("mode flag differs from bank bit 7");
    a_four_byte_addr: assert property (bank_out[7] |=> eff_addr_out == $past(req_in.addr))
        else $error("four-byte address altered");
    a_segment_addr: assert property (!bank_out[7] && !req_in.wide |=>
        eff_addr_out == {1'b0, $past(bank_out[6:0]), $past(req_in.addr[23:0])}) else $error("segment address wrong");
    a_wide_addr: assert property (req_in.wide |=> eff_addr_out == $past(req_in.addr))
        else $error("wide command address altered");
    a_soft_clear: assert property (soft_reset_in |=> bank_out == 8'h00)
        else $error("soft reset left bank set");
    a_reset_zero: assert property ($fell(rst_in) |-> bank_out == 8'h00)
        else $error("bank not zero after reset");
    a_idle_quiet: assert property (cs_n_in [*6] |-> !miso_oe_out)
        else $error("output driven while deselected");
    a_oe_selected: assert property ($rose(miso_oe_out) |-> !$past(cs_n_in, 4))
        else $error("output enabled without select");
    a_bank_hold: assert property ((cs_n_in && !soft_reset_in) [*6] |=> $stable(bank_out))
        else $error("bank changed while idle");
    cover property (bank_out[7] && req_in.wide);
    cover property ($rose(miso_oe_out));
    cover property (soft_reset_in && bank_out != 8'h00);
endmodule

// >>> testbench/fab_host.sv
// SPI host model issuing bank commands
`timescale 1ns/1ps
module fab_host (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
    // Mode 0, MSB first; slow halves give the sync chain room
    task automatic xfer(input logic [7:0] c, input logic [7:0] d, input int n, output logic [7:0] r);
        logic [15:0] s;
        s = {c, d};
        r = 8'h00;
        cs_n_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < 8 + n; i++) begin
            mosi_out <= s[15 - i];
            repeat (8) @(posedge clk_in);
            sclk_out <= 1'b1;
            r = {r[6:0], miso_in};
            repeat (8) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (8) @(posedge clk_in);
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// >>> testbench/fab_bank_bench.sv
// Testbench for the bank register block
`timescale 1ns/1ps
module fab_bank_bench;
    logic mclk_in, rst_in, soft_reset_in, cs_n, sclk, mosi, miso, oe, four_byte;
    logic [31:0] eff;
    logic [7:0] bank, rd;
    fab_pkg::fab_addr_req_t req;
    int errors = 0;
    int n_tests = 0;
    fab_bank u_dut (.mclk_in, .rst_in, .soft_reset_in, .cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi),
        .req_in(req), .miso_out(miso), .miso_oe_out(oe), .eff_addr_out(eff), .four_byte_out(four_byte),
        .bank_out(bank));
    fab_host u_host (.clk_in(mclk_in), .miso_in(oe ? miso : ~miso), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] e);
        req <= '{a, w};
        repeat (2) @(posedge mclk_in);
        chk("eff_addr", e, eff);
    endtask
    task automatic test_done;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        errors++;
        test_done;
    end
    initial begin
        rst_in = 1'b1;
        soft_reset_in = 1'b0;
        req = '0;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        chk("bank", 8'h00, bank);
        chk("four_byte", 1'b0, four_byte);
        u_host.xfer(8'h16, 8'h00, 8, rd);
        chk("read", 8'h00, rd);
        chk("oe", 1'b0, oe);
        u_host.xfer(8'h17, 8'hA5, 8, rd);
        chk("bank", 8'hA5, bank);
        chk("four_byte", 1'b1, four_byte);
        u_host.xfer(8'h16, 8'h00, 8, rd);
        chk("read", 8'hA5, rd);
        acc(32'h8123_4567, 1'b0, 32'h8123_4567);
        u_host.xfer(8'h17, 8'h05, 8, rd);
        chk("four_byte", 1'b0, four_byte);
        acc(32'hFF12_3456, 1'b0, 32'h0512_3456);
        acc(32'hFF12_3456, 1'b1, 32'hFF12_3456);
        u_host.xfer(8'h17, 8'hF0, 4, rd);
        chk("bank", 8'h05, bank);
        u_host.xfer(8'h18, 8'hF0, 8, rd);
        chk("bank", 8'h05, bank);
        u_host.xfer(8'h17, 8'h80, 8, rd);
        chk("bank", 8'h80, bank);
        soft_reset_in <= 1'b1;
        @(posedge mclk_in);
        soft_reset_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("bank", 8'h00, bank);
        chk("four_byte", 1'b0, four_byte);
        test_done;
    end
endmodule
bind fab_bank fab_checker u_chk (.mclk_in, .rst_in, .soft_reset_in, .cs_n_in, .req_in, .miso_oe_out,
    .eff_addr_out, .four_byte_out, .bank_out);
